// [rtl/psm_mapper.sv]
// program space access mapper: table and remap window paths to program memory
// assumes core, register port and program memory all run on mclk_i
//
// Summary of operation
// R1: table address is page above effective address
// R2: page msb selects configuration or user space
// R3: remap address is visibility page plus ea[14:0]
// R4: remap reads never reach configuration space
// R5: program bit 15 comes from visibility page bit 0
// R6: generated program address lsb is always zero
// R7: table accesses allow any byte address, byte/word
// R8: program counter advances by two per word
// R9: word low read returns program bits 15:0
// R10: byte low read selects byte by byte select
// R11: word high read zeros the phantom byte
// R12: byte high read: bits 23:16 or zero
// R13: configuration space allows table reads only
// R14: remap window is read-only, low word only
// R15: high table ops alone reach upper byte
// R16: remap only while remap enable bit set
// R17: remap read costs an extra program fetch
// R18: no remap access during a table operation
// R19: configuration table write ignored, nothing disturbed
`timescale 1ns/100ps
`default_nettype none

module psm_mapper
    import psm_pkg::*;
(
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    // register port
    input  wire logic [PSM_RW-1:0] reg_addr_i,
    input  wire logic [15:0]       reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [15:0]       reg_rdata_o,
    // core access port
    input  wire logic              core_req_i,
    input  wire psm_core_req_t     core_cmd_i,
    output logic                   core_ready_o,
    output logic                   core_done_o,
    output logic      [15:0]       core_rdata_o,
    output logic                   core_unmapped_o,
    output logic                   core_ignored_o,
    // program counter
    input  wire logic              pc_step_i,
    input  wire logic              pc_load_i,
    input  wire logic [23:0]       pc_load_val_i,
    output logic      [23:0]       pc_fetch_addr_o,
    // program memory port
    output logic                   pm_req_o,
    output psm_pm_req_t            pm_cmd_o,
    input  wire logic              pm_ack_i,
    input  wire logic [23:0]       pm_rdata_i
);

    typedef enum logic [2:0] {ST_IDLE, ST_FETCH1, ST_FETCH2, ST_WRITE, ST_RESP} psm_state_t;

    function automatic logic [23:0] psm_table_addr(input logic [7:0] page, input logic [15:0] ea);
        psm_table_addr = {page, ea[15:1], 1'b0};
    endfunction

    function automatic logic [23:0] psm_remap_addr(input logic [7:0] page, input logic [15:0] ea);
        psm_remap_addr = {1'b0, page, ea[14:1], 1'b0};
    endfunction

    psm_state_t    state_r;
    psm_state_t    state_nxt;
    logic [7:0]    table_page_r;
    logic [7:0]    vis_page_r;
    logic [15:0]   core_ctrl_r;
    logic [7:0]    ign_cnt_r;
    psm_core_req_t cmd_r;
    logic          miss_r;
    logic          ign_r;
    logic [23:0]   word_r;
    logic [15:0]   lane_data;
    logic          accept;
    logic          remap_en;
    logic          is_data_rd;
    logic          is_write;
    logic          cfg_space;
    logic          remap_hit;
    logic [15:0]   status;

    assign remap_en   = core_ctrl_r[PSM_REMAP_EN_BIT];
    assign accept     = core_req_i && core_ready_o; // R18
    assign is_data_rd = (core_cmd_i.op == PSM_OP_DATA_READ);
    assign is_write   = (core_cmd_i.op == PSM_OP_WR_LOW) || (core_cmd_i.op == PSM_OP_WR_HIGH);
    assign cfg_space  = table_page_r[PSM_CFG_SPACE_BIT]; // R2
    assign remap_hit  = is_data_rd && core_cmd_i.effective_address[PSM_EA_MSB] && remap_en; // R16 R14

    always_comb begin
        status = 16'h0000;
        status[PSM_ST_REMAP_BIT] = remap_en;
        status[PSM_ST_BUSY_BIT] = !core_ready_o;
        status[PSM_ST_CNT_LSB +: 8] = ign_cnt_r;
    end

    // register writes
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            table_page_r <= PSM_TABLE_PAGE_RST;
            vis_page_r   <= PSM_VIS_PAGE_RST;
            core_ctrl_r  <= PSM_CORE_CTRL_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == PSM_OFS_TABLE_PAGE) begin
                table_page_r <= reg_wdata_i[7:0];
            end
            if (reg_addr_i == PSM_OFS_VIS_PAGE) begin
                vis_page_r <= reg_wdata_i[7:0];
            end
            if (reg_addr_i == PSM_OFS_CORE_CTRL) begin
                core_ctrl_r <= reg_wdata_i;
            end
        end
    end

    // register reads, data valid the cycle after the strobe only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                PSM_OFS_TABLE_PAGE: reg_rdata_o <= {8'h00, table_page_r};
                PSM_OFS_VIS_PAGE:   reg_rdata_o <= {8'h00, vis_page_r};
                PSM_OFS_CORE_CTRL:  reg_rdata_o <= core_ctrl_r;
                PSM_OFS_STATUS:     reg_rdata_o <= status;
                default:            reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // access sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    if (is_data_rd) begin
                        state_nxt = remap_hit ? ST_FETCH1 : ST_RESP;
                    end else if (is_write) begin
                        state_nxt = cfg_space ? ST_RESP : ST_WRITE; // R13 R19
                    end else begin
                        state_nxt = ST_FETCH2;
                    end
                end
            end
            ST_FETCH1: if (pm_ack_i) state_nxt = ST_FETCH2; // R17
            ST_FETCH2, ST_WRITE: if (pm_ack_i) state_nxt = ST_RESP;
            ST_RESP: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r      <= ST_IDLE;
            core_ready_o <= 1'b0;
            pm_req_o     <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            core_ready_o <= (state_nxt == ST_IDLE);
            pm_req_o     <= (state_nxt == ST_FETCH1) || (state_nxt == ST_FETCH2) || (state_nxt == ST_WRITE);
        end
    end

    // command capture and program memory request forming
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_r    <= '0;
            miss_r   <= 1'b0;
            ign_r    <= 1'b0;
            pm_cmd_o <= '0;
        end else if (accept) begin
            cmd_r            <= core_cmd_i;
            miss_r           <= is_data_rd && !remap_hit;
            ign_r            <= is_write && cfg_space; // R19
            pm_cmd_o.we      <= is_write;
            pm_cmd_o.lane_en <= 3'b000;
            pm_cmd_o.wdata   <= 24'h000000;
            if (is_data_rd) begin
                pm_cmd_o.addr <= psm_remap_addr(vis_page_r, core_cmd_i.effective_address); // R3 R4 R5 R6
            end else begin
                pm_cmd_o.addr <= psm_table_addr(table_page_r, core_cmd_i.effective_address); // R1 R6 R7
            end
            case (core_cmd_i.op)
                PSM_OP_WR_LOW: begin
                    if (!core_cmd_i.byte_mode) begin
                        pm_cmd_o.lane_en <= 3'b011;
                        pm_cmd_o.wdata   <= {8'h00, core_cmd_i.wdata};
                    end else if (core_cmd_i.effective_address[0]) begin
                        pm_cmd_o.lane_en <= 3'b010;
                        pm_cmd_o.wdata   <= {8'h00, core_cmd_i.wdata[7:0], 8'h00};
                    end else begin
                        pm_cmd_o.lane_en <= 3'b001;
                        pm_cmd_o.wdata   <= {16'h0000, core_cmd_i.wdata[7:0]};
                    end
                end
                PSM_OP_WR_HIGH: begin
                    // phantom byte write touches no lane
                    if (!(core_cmd_i.byte_mode && core_cmd_i.effective_address[0])) begin
                        pm_cmd_o.lane_en <= 3'b100; // R15
                        pm_cmd_o.wdata   <= {core_cmd_i.wdata[7:0], 16'h0000};
                    end
                end
                default: pm_cmd_o.lane_en <= 3'b000;
            endcase
        end
    end

    // ignored configuration writes counter
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ign_cnt_r <= PSM_IGN_CNT_RST;
        end else if (accept && is_write && cfg_space) begin
            ign_cnt_r <= ign_cnt_r + 8'h01;
        end
    end

    // program word capture, second fetch wins
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_r <= 24'h000000;
        end else if (pm_ack_i && ((state_r == ST_FETCH1) || (state_r == ST_FETCH2))) begin
            word_r <= pm_rdata_i;
        end
    end

    psm_read_lane u_lane (
        .op_i        (cmd_r.op),
        .byte_mode_i (cmd_r.byte_mode && (cmd_r.op != PSM_OP_DATA_READ)),
        .bsel_i      (cmd_r.effective_address[0]),
        .word_i      (word_r),
        .data_o      (lane_data)
    );

    // core answer
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_done_o     <= 1'b0;
            core_rdata_o    <= 16'h0000;
            core_unmapped_o <= 1'b0;
            core_ignored_o  <= 1'b0;
        end else begin
            core_done_o     <= (state_r == ST_RESP);
            core_unmapped_o <= (state_r == ST_RESP) && miss_r;
            core_ignored_o  <= (state_r == ST_RESP) && ign_r;
            if ((state_r == ST_RESP) && !miss_r && !cmd_r.op[2] && !(cmd_r.op == PSM_OP_WR_LOW)) begin
                core_rdata_o <= lane_data; // R14
            end else begin
                core_rdata_o <= 16'h0000;
            end
        end
    end

    // program counter
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_fetch_addr_o <= PSM_PC_RST;
        end else if (pc_load_i) begin
            pc_fetch_addr_o <= {1'b0, pc_load_val_i[22:1], 1'b0}; // R6
        end else if (pc_step_i) begin
            pc_fetch_addr_o <= {1'b0, pc_fetch_addr_o[22:0] + PSM_PC_STEP}; // R8
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    property p_table_addr;
        accept && !is_data_rd && !(is_write && cfg_space)
            |=> pm_req_o && pm_cmd_o.addr == psm_table_addr($past(table_page_r), $past(core_cmd_i.effective_address));
    endproperty
    a_table_addr: assert property (p_table_addr) else $error("table address wrong"); // R1

    property p_cfg_write;
        accept && is_write && cfg_space |=> !pm_req_o ##1 core_done_o && core_ignored_o && !pm_req_o;
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not ignored"); // R13

    property p_remap_addr;
        accept && remap_hit
            |=> state_r == ST_FETCH1 && pm_cmd_o.addr == psm_remap_addr($past(vis_page_r), $past(core_cmd_i.effective_address));
    endproperty
    a_remap_addr: assert property (p_remap_addr) else $error("remap address wrong"); // R3

    property p_remap_user;
        pm_req_o && !pm_cmd_o.we && cmd_r.op == PSM_OP_DATA_READ |-> !pm_cmd_o.addr[23] && pm_cmd_o.addr[15] == vis_page_r[0];
    endproperty
    a_remap_user: assert property (p_remap_user) else $error("remap left user space"); // R4

    property p_lsb_zero;
        (pm_req_o |-> !pm_cmd_o.addr[0]) and (!pc_fetch_addr_o[0]);
    endproperty
    a_lsb_zero: assert property (p_lsb_zero) else $error("address lsb not zero"); // R6

    property p_pc_step;
        pc_step_i && !pc_load_i |=> pc_fetch_addr_o[22:0] == $past(pc_fetch_addr_o[22:0]) + PSM_PC_STEP;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step not two"); // R8

    property p_remap_off;
        accept && is_data_rd && !remap_en |=> !pm_req_o ##1 core_done_o && core_unmapped_o;
    endproperty
    a_remap_off: assert property (p_remap_off) else $error("remap while disabled"); // R16

    property p_two_fetch;
        state_r == ST_FETCH1 && pm_ack_i |=> state_r == ST_FETCH2 && pm_req_o && !core_done_o;
    endproperty
    a_two_fetch: assert property (p_two_fetch) else $error("second fetch missing"); // R17

    property p_no_overlap;
        (state_r == ST_WRITE || (state_r == ST_FETCH2 && cmd_r.op != PSM_OP_DATA_READ)) |-> !core_ready_o;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("remap open during table op"); // R18

    property p_high_word;
        state_r == ST_RESP && cmd_r.op == PSM_OP_RD_HIGH && !cmd_r.byte_mode
            |=> core_rdata_o == {8'h00, $past(word_r[23:16])};
    endproperty
    a_high_word: assert property (p_high_word) else $error("high read wrong"); // R11

    property p_low_word;
        state_r == ST_RESP && cmd_r.op == PSM_OP_RD_LOW && !cmd_r.byte_mode |=> core_rdata_o == $past(word_r[15:0]);
    endproperty
    a_low_word: assert property (p_low_word) else $error("low read wrong"); // R9

    c_remap_read: cover property (accept && remap_hit ##[2:20] core_done_o);
    c_table_write: cover property (accept && is_write && !cfg_space ##[1:20] core_done_o);
    c_cfg_ignored: cover property (core_done_o && core_ignored_o);

endmodule

`default_nettype wire

// [common/psm_pkg.sv]
// shared constants and types for the program space access mapper
// assumes a 16-bit core data path and a 24-bit program memory word
package psm_pkg;

    localparam int PSM_DW = 16;
    localparam int PSM_PW = 24;
    localparam int PSM_RW = 8;

    // register offsets on the plain register port
    localparam logic [PSM_RW-1:0] PSM_OFS_TABLE_PAGE = 8'h00;
    localparam logic [PSM_RW-1:0] PSM_OFS_VIS_PAGE   = 8'h04;
    localparam logic [PSM_RW-1:0] PSM_OFS_CORE_CTRL  = 8'h08;
    localparam logic [PSM_RW-1:0] PSM_OFS_STATUS     = 8'h0c;

    // reset values
    localparam logic [7:0]  PSM_TABLE_PAGE_RST = 8'h00;
    localparam logic [7:0]  PSM_VIS_PAGE_RST   = 8'h00;
    localparam logic [15:0] PSM_CORE_CTRL_RST  = 16'h0000;
    localparam logic [23:0] PSM_PC_RST         = 24'h000000;
    localparam logic [7:0]  PSM_IGN_CNT_RST    = 8'h00;

    // field positions
    localparam int PSM_REMAP_EN_BIT  = 2;
    localparam int PSM_CFG_SPACE_BIT = 7;
    localparam int PSM_EA_MSB        = 15;
    localparam int PSM_ST_REMAP_BIT  = 0;
    localparam int PSM_ST_BUSY_BIT   = 1;
    localparam int PSM_ST_CNT_LSB    = 8;

    // program counter step per program word
    localparam logic [22:0] PSM_PC_STEP = 23'h000002;

    typedef enum logic [2:0] {
        PSM_OP_DATA_READ,
        PSM_OP_RD_LOW,
        PSM_OP_RD_HIGH,
        PSM_OP_WR_LOW,
        PSM_OP_WR_HIGH
    } psm_op_t;

    typedef struct packed {
        psm_op_t           op;
        logic              byte_mode;
        logic [PSM_DW-1:0] effective_address;
        logic [PSM_DW-1:0] wdata;
    } psm_core_req_t;

    typedef struct packed {
        logic [PSM_PW-1:0] addr;
        logic              we;
        logic [2:0]        lane_en;
        logic [PSM_PW-1:0] wdata;
    } psm_pm_req_t;

endpackage

// [rtl/psm_read_lane.sv]
// read lane steering from a 24-bit program word onto the 16-bit data path
// assumes a same-clock caller that registers the result
`timescale 1ns/100ps
`default_nettype none

module psm_read_lane
    import psm_pkg::*;
(
    // selection
    input  wire psm_op_t      op_i,
    input  wire logic         byte_mode_i,
    input  wire logic         bsel_i,
    // data
    input  wire logic [23:0]  word_i,
    output logic      [15:0]  data_o
);

    always_comb begin
        data_o = 16'h0000;
        case (op_i)
            PSM_OP_RD_HIGH: begin
                if (byte_mode_i) begin
                    data_o = bsel_i ? 16'h0000 : {8'h00, word_i[23:16]}; // R12
                end else begin
                    data_o = {8'h00, word_i[23:16]}; // R11
                end
            end
            PSM_OP_RD_LOW, PSM_OP_DATA_READ: begin
                if (byte_mode_i) begin
                    data_o = {8'h00, bsel_i ? word_i[15:8] : word_i[7:0]}; // R10
                end else begin
                    data_o = word_i[15:0]; // R9
                end
            end
            default: data_o = 16'h0000;
        endcase
    end

endmodule

`default_nettype wire

// [tb/psm_pm_model.sv]
// behavioural program memory on the far side of the mapper
// assumes one clock shared with the mapper; latency set by lat_i
`timescale 1ns/100ps
`default_nettype none

module psm_pm_model
    import psm_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // answer delay in cycles
    input  wire logic [3:0]  lat_i,
    // memory port
    input  wire logic        pm_req_i,
    input  wire psm_pm_req_t pm_cmd_i,
    output logic             pm_ack_o,
    output logic [23:0]      pm_rdata_o
);
    logic [23:0] mem [logic [23:0]];
    logic [3:0]  cnt_r;
    psm_pm_req_t last_r;
    int          acks_r;
    logic [23:0] w_v;

    // unwritten words hold a fixed pattern
    function automatic logic [23:0] pat(input logic [23:0] a);
        return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h3c69};
    endfunction

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pm_ack_o   <= 1'b0;
            cnt_r      <= 4'h0;
            acks_r     <= 0;
            pm_rdata_o <= 24'h5a5a5a;
        end else if (pm_ack_o || !pm_req_i) begin
            // released bus shows a changing pattern
            pm_ack_o   <= 1'b0;
            pm_rdata_o <= ~pm_rdata_o;
        end else if (cnt_r == lat_i) begin
            w_v = mem.exists(pm_cmd_i.addr) ? mem[pm_cmd_i.addr] : pat(pm_cmd_i.addr);
            pm_ack_o   <= 1'b1;
            cnt_r      <= 4'h0;
            last_r     <= pm_cmd_i;
            acks_r     <= acks_r + 1;
            pm_rdata_o <= w_v;
            if (pm_cmd_i.we) begin
                for (int i = 0; i < 3; i++) begin
                    if (pm_cmd_i.lane_en[i]) begin
                        w_v[8*i+:8] = pm_cmd_i.wdata[8*i+:8];
                    end
                end
                mem[pm_cmd_i.addr] = w_v;
            end
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

`default_nettype wire

// [tb/program_space_access_mapper_tb.sv]
// self-checking bench for the mapper with a program memory model
// assumes psm_pkg compiled first; single 100 MHz clock
`timescale 1ns/100ps
`default_nettype none

module program_space_access_mapper_tb
    import psm_pkg::*;
;
    logic mclk_i = 1'b0, rst_b_i = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, core_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, core_req = 1'b0;
    psm_core_req_t core_cmd = '0;
    logic core_ready, core_done, unmapped, ignored, pm_req, pm_ack;
    logic pc_step = 1'b0, pc_load = 1'b0, busy_seen;
    logic [23:0] pc_load_val = 24'h000000, pc_addr, pm_rdata, w;
    psm_pm_req_t pm_cmd;
    logic [3:0] lat = 4'h0;
    int mismatches = 0, checks_done = 0, acks_seen;

    always #5 mclk_i = ~mclk_i;

    psm_mapper u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .core_req_i(core_req), .core_cmd_i(core_cmd), .core_ready_o(core_ready),
        .core_done_o(core_done), .core_rdata_o(core_rdata), .core_unmapped_o(unmapped),
        .core_ignored_o(ignored), .pc_step_i(pc_step), .pc_load_i(pc_load),
        .pc_load_val_i(pc_load_val), .pc_fetch_addr_o(pc_addr), .pm_req_o(pm_req),
        .pm_cmd_o(pm_cmd), .pm_ack_i(pm_ack), .pm_rdata_i(pm_rdata));

    psm_pm_model u_mem (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .lat_i(lat), .pm_req_i(pm_req),
        .pm_cmd_i(pm_cmd), .pm_ack_o(pm_ack), .pm_rdata_o(pm_rdata));

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [15:0] e, input string nm);
        @(posedge mclk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk_i);
        reg_rd <= 1'b0;
        #1 chk(nm, {8'h00, reg_rdata}, {8'h00, e});
    endtask

    // one core access, waits for done and leaves outputs of that cycle visible
    task automatic acc(input psm_op_t op, input logic bm, input logic [15:0] ea, input logic [15:0] wd);
        int n;
        int a0;
        n = 0;
        a0 = u_mem.acks_r;
        @(posedge mclk_i);
        core_req <= 1'b1;
        core_cmd <= '{op, bm, ea, wd};
        do begin
            @(posedge mclk_i);
            n++;
        end while (core_ready !== 1'b1 && n < 100);
        core_req <= 1'b0;
        #1 busy_seen = core_ready;
        while (core_done !== 1'b1 && n < 100) begin
            @(posedge mclk_i);
            #1 n++;
        end
        if (n >= 100) mismatches++;
        acks_seen = u_mem.acks_r - a0;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        // register reset values and access kinds
        reg_read(PSM_OFS_TABLE_PAGE, 16'h0000, "page rst");
        reg_read(PSM_OFS_CORE_CTRL, 16'h0000, "ctrl rst");
        reg_write(PSM_OFS_CORE_CTRL, 16'hf0f0);
        reg_write(8'h10, 16'hffff);
        reg_write(PSM_OFS_STATUS, 16'hffff);
        reg_read(8'h10, 16'h0000, "unmapped reg");
        reg_read(PSM_OFS_STATUS, 16'h0000, "status");
        reg_read(PSM_OFS_CORE_CTRL, 16'hf0f0, "ctrl");
        @(posedge mclk_i);
        #1 chk("rdata after", {8'h00, reg_rdata}, 24'h000000);
        $display("test registers done");
        // table reads, page above ea, all lane selections
        reg_write(PSM_OFS_TABLE_PAGE, 16'h0012);
        lat <= 4'h2;
        w = u_mem.pat(24'h123456);
        acc(PSM_OP_RD_LOW, 1'b0, 16'h3456, 16'h0000);
        chk("busy", {23'h0, busy_seen}, 24'h0);
        chk("pm addr", u_mem.last_r.addr, 24'h123456);
        chk("rd low word", {8'h00, core_rdata}, {8'h00, w[15:0]});
        acc(PSM_OP_RD_LOW, 1'b1, 16'h3457, 16'h0000);
        chk("pm addr odd", u_mem.last_r.addr, 24'h123456);
        chk("rd low sel1", {8'h00, core_rdata}, {16'h0000, w[15:8]});
        acc(PSM_OP_RD_LOW, 1'b1, 16'h3456, 16'h0000);
        chk("rd low sel0", {8'h00, core_rdata}, {16'h0000, w[7:0]});
        acc(PSM_OP_RD_HIGH, 1'b0, 16'h3457, 16'h0000);
        chk("rd high word", {8'h00, core_rdata}, {16'h0000, w[23:16]});
        acc(PSM_OP_RD_HIGH, 1'b1, 16'h3456, 16'h0000);
        chk("rd high sel0", {8'h00, core_rdata}, {16'h0000, w[23:16]});
        acc(PSM_OP_RD_HIGH, 1'b1, 16'h3457, 16'h0000);
        chk("rd high sel1", {8'h00, core_rdata}, 24'h000000);
        $display("test table reads done");
        // table writes to user space, then read back
        lat <= 4'h0;
        acc(PSM_OP_WR_LOW, 1'b0, 16'h2000, 16'hbeef);
        chk("wr low lanes", {21'h0, u_mem.last_r.lane_en}, 24'h000003);
        chk("wr low data", u_mem.last_r.wdata, 24'h00beef);
        acc(PSM_OP_WR_HIGH, 1'b0, 16'h2000, 16'h0077);
        chk("wr high lanes", {21'h0, u_mem.last_r.lane_en}, 24'h000004);
        acc(PSM_OP_RD_HIGH, 1'b0, 16'h2000, 16'h0000);
        chk("rd high back", {8'h00, core_rdata}, 24'h000077);
        acc(PSM_OP_RD_LOW, 1'b0, 16'h2000, 16'h0000);
        chk("rd low back", {8'h00, core_rdata}, 24'h00beef);
        // byte writes: each low lane alone, phantom byte touches none
        acc(PSM_OP_WR_LOW, 1'b1, 16'h2001, 16'h0012);
        chk("wr sel1 lanes", {21'h0, u_mem.last_r.lane_en}, 24'h000002);
        chk("wr sel1 data", u_mem.last_r.wdata, 24'h001200);
        acc(PSM_OP_WR_LOW, 1'b1, 16'h2000, 16'h0034);
        chk("wr sel0 lanes", {21'h0, u_mem.last_r.lane_en}, 24'h000001);
        chk("wr sel0 data", u_mem.last_r.wdata, 24'h000034);
        acc(PSM_OP_WR_HIGH, 1'b1, 16'h2001, 16'h0055);
        chk("wr phantom lanes", {21'h0, u_mem.last_r.lane_en}, 24'h000000);
        acc(PSM_OP_RD_LOW, 1'b0, 16'h2000, 16'h0000);
        chk("rd bytes back", {8'h00, core_rdata}, 24'h001234);
        acc(PSM_OP_RD_HIGH, 1'b0, 16'h2000, 16'h0000);
        chk("rd phantom kept", {8'h00, core_rdata}, 24'h000077);
        $display("test table writes done");
        // configuration space: write dropped, read allowed
        reg_write(PSM_OFS_TABLE_PAGE, 16'h0080);
        acc(PSM_OP_WR_LOW, 1'b0, 16'h0000, 16'h1234);
        chk("cfg wr ignored", {22'h0, ignored, unmapped}, 24'h000002);
        chk("cfg wr no access", acks_seen[23:0], 24'h0);
        reg_read(PSM_OFS_STATUS, 16'h0100, "ignored count");
        acc(PSM_OP_RD_LOW, 1'b0, 16'h0002, 16'h0000);
        chk("cfg rd addr", u_mem.last_r.addr, 24'h800002);
        w = u_mem.pat(24'h800002);
        chk("cfg rd data", {8'h00, core_rdata}, {8'h00, w[15:0]});
        $display("test config space done");
        // remap window off, then on
        reg_write(PSM_OFS_VIS_PAGE, 16'h0081);
        reg_write(PSM_OFS_CORE_CTRL, 16'h0000);
        acc(PSM_OP_DATA_READ, 1'b0, 16'h8abc, 16'h0000);
        chk("remap off", {7'h0, unmapped, core_rdata}, 24'h010000);
        chk("remap off acks", acks_seen[23:0], 24'h0);
        reg_write(PSM_OFS_CORE_CTRL, 16'h0004);
        reg_read(PSM_OFS_STATUS, 16'h0101, "status remap");
        acc(PSM_OP_DATA_READ, 1'b0, 16'h1234, 16'h0000);
        chk("low half", {7'h0, unmapped, core_rdata}, 24'h010000);
        lat <= 4'h3;
        acc(PSM_OP_DATA_READ, 1'b0, 16'h8abd, 16'h0000);
        chk("remap addr", u_mem.last_r.addr, {1'b0, 8'h81, 15'h0abc});
        chk("remap fetches", acks_seen[23:0], 24'h2);
        chk("remap busy", {23'h0, busy_seen}, 24'h0);
        w = u_mem.pat({1'b0, 8'h81, 15'h0abc});
        chk("remap data", {7'h0, unmapped, core_rdata}, {8'h00, w[15:0]});
        chk("remap read only", {23'h0, u_mem.last_r.we}, 24'h0);
        $display("test remap done");
        // program counter
        @(posedge mclk_i);
        pc_load <= 1'b1;
        pc_load_val <= 24'h800011;
        @(posedge mclk_i);
        pc_load <= 1'b0;
        pc_step <= 1'b1;
        @(posedge mclk_i);
        pc_step <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 chk("pc", pc_addr, 24'h000012);
        $display("test program counter done");
        end_of_test();
    end
endmodule

`default_nettype wire
